// ### design/bps_pkg.sv
// shared constants and carrier types for the baseband packet segmenter
package bps_pkg;
    // register byte offsets
    localparam logic [7:0] BPS_REG_CTRL     = 8'h00;
    localparam logic [7:0] BPS_REG_PIPE     = 8'h04;
    localparam logic [7:0] BPS_REG_TSTAMP   = 8'h08;
    localparam logic [7:0] BPS_REG_SEGMAX   = 8'h0c;
    localparam logic [7:0] BPS_REG_STATUS   = 8'h10;
    localparam logic [7:0] BPS_REG_IRQ_STAT = 8'h14;
    localparam logic [7:0] BPS_REG_IRQ_CLR  = 8'h18;
    localparam logic [7:0] BPS_REG_IRQ_EN   = 8'h1c;
    localparam logic [7:0] BPS_REG_SEQ      = 8'h20;
    localparam logic [7:0] BPS_REG_EMIT_SEC = 8'h24;
    localparam logic [7:0] BPS_REG_EMIT_NS  = 8'h28;
    // control fields
    localparam int BPS_CTRL_ENABLE_BIT = 0;
    localparam int BPS_CTRL_EXT_BIT    = 1;
    localparam int BPS_CTRL_PAD_BIT    = 2;
    localparam int BPS_CTRL_TSSRC_BIT  = 3;
    // pipe register fields
    localparam int BPS_PIPE_LSB  = 0;
    localparam int BPS_PIPE_W    = 6;
    localparam int BPS_CHOFF_LSB = 8;
    localparam int BPS_CHOFF_W   = 8;
    // interrupt bits
    localparam int BPS_IRQ_SET_DONE = 0;
    localparam int BPS_IRQ_PKT_DONE = 1;
    localparam int BPS_IRQ_W        = 2;
    // reset values
    localparam logic [15:0] BPS_SEGMAX_RST = 16'd1460;
    localparam logic [31:0] BPS_CTRL_RST   = 32'h0000_0001;
    // rtp and ip constants
    localparam logic [31:0] BPS_MCAST_ADDR = {8'd239, 8'd0, 8'd51, 8'd48};
    localparam logic [15:0] BPS_PORT_BASE  = 16'd30000;
    localparam logic [1:0]  BPS_RTP_VER    = 2'h2;
    localparam logic [6:0]  BPS_PT_BASEBAND = 7'h4e;
    localparam logic [3:0]  BPS_CSRC_COUNT = 4'h0;
    localparam int          BPS_TS_SEC_W   = 22;
    localparam int          BPS_TS_NS_MSB  = 29;  // 3rd msb of 32-bit value
    localparam int          BPS_TS_NS_W    = 10;
    // axi answers
    localparam logic [1:0]  BPS_RESP_OKAY   = 2'b00;
    localparam logic [1:0]  BPS_RESP_SLVERR = 2'b10;

    // header of one segment packet
    typedef struct packed {
        logic [31:0] dst_addr;
        logic [15:0] dst_port;
        logic [1:0]  version;
        logic        padding;
        logic        extension;
        logic [3:0]  csrc_count;
        logic        marker;
        logic [6:0]  payload_type;
        logic [15:0] seq_num;
        logic [31:0] timestamp;
        logic [31:0] ssrc;
        logic [15:0] pay_len;
    } bps_hdr_s;

    // byte stream beat
    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } bps_beat_s;
endpackage

// ### design/bps_axil_regs.sv
// axi4-lite register slave for the baseband packet segmenter
`timescale 1ns/10ps
`default_nettype none
module bps_axil_regs (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic [31:0]               ctrl_q,
    output logic [31:0]               pipe_q,
    output logic [31:0]               tstamp_q,
    output logic [31:0]               segmax_q,
    output logic [31:0]               emit_sec_q,
    output logic [31:0]               emit_ns_q,
    output logic [bps_pkg::BPS_IRQ_W-1:0] irq_en_q,
    output logic [bps_pkg::BPS_IRQ_W-1:0] irq_clr,
    input  wire logic [bps_pkg::BPS_IRQ_W-1:0] irq_stat,
    input  wire logic [31:0]          status,
    input  wire logic [15:0]          seq_now
);
    import bps_pkg::*;

    logic [7:0]  aw_q;
    logic        aw_have_q;
    logic [31:0] w_q;
    logic [3:0]  ws_q;
    logic        w_have_q;
    logic        do_wr;

    // merge strobed bytes into an old value
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // address decode shared by reads and writes
    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a <= BPS_REG_EMIT_NS);
    endfunction

    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
    assign do_wr = aw_have_q && w_have_q && !s_axi_bvalid;

    // address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_q      <= 8'h00;
            w_q       <= 32'h0000_0000;
            ws_q      <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q      <= s_axi_awaddr;
                aw_have_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q      <= s_axi_wdata;
                ws_q     <= s_axi_wstrb;
                w_have_q <= 1'b1;
            end
            if (do_wr) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
            end
        end
    end

    // write response one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= BPS_RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(aw_q) ? BPS_RESP_OKAY : BPS_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // writable registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q     <= BPS_CTRL_RST;
            pipe_q     <= 32'h0000_0000;
            tstamp_q   <= 32'h0000_0000;
            segmax_q   <= {16'h0000, BPS_SEGMAX_RST};
            emit_sec_q <= 32'h0000_0000;
            emit_ns_q  <= 32'h0000_0000;
            irq_en_q   <= '0;
        end else if (do_wr) begin
            case (aw_q)
                BPS_REG_CTRL:     ctrl_q     <= merge(ctrl_q, w_q, ws_q);
                BPS_REG_PIPE:     pipe_q     <= merge(pipe_q, w_q, ws_q);
                BPS_REG_TSTAMP:   tstamp_q   <= merge(tstamp_q, w_q, ws_q);
                BPS_REG_SEGMAX:   segmax_q   <= merge(segmax_q, w_q, ws_q);
                BPS_REG_EMIT_SEC: emit_sec_q <= merge(emit_sec_q, w_q, ws_q);
                BPS_REG_EMIT_NS:  emit_ns_q  <= merge(emit_ns_q, w_q, ws_q);
                BPS_REG_IRQ_EN:   irq_en_q   <= w_q[BPS_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // clear register is write-only, a one-cycle pulse per written one
    assign irq_clr = (do_wr && aw_q == BPS_REG_IRQ_CLR && ws_q[0])
                     ? w_q[BPS_IRQ_W-1:0] : '0;

    // read channel answers one cycle after the address is taken
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= BPS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= mapped(s_axi_araddr) ? BPS_RESP_OKAY
                                                 : BPS_RESP_SLVERR;
            case (s_axi_araddr)
                BPS_REG_CTRL:     s_axi_rdata <= ctrl_q;
                BPS_REG_PIPE:     s_axi_rdata <= pipe_q;
                BPS_REG_TSTAMP:   s_axi_rdata <= tstamp_q;
                BPS_REG_SEGMAX:   s_axi_rdata <= segmax_q;
                BPS_REG_STATUS:   s_axi_rdata <= status;
                BPS_REG_IRQ_STAT: s_axi_rdata <= {30'h0, irq_stat};
                BPS_REG_IRQ_EN:   s_axi_rdata <= {30'h0, irq_en_q};
                BPS_REG_SEQ:      s_axi_rdata <= {16'h0000, seq_now};
                BPS_REG_EMIT_SEC: s_axi_rdata <= emit_sec_q;
                BPS_REG_EMIT_NS:  s_axi_rdata <= emit_ns_q;
                default:          s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### design/bps_segmenter.sv
// baseband structure to rtp segment packet framer with register slave
`timescale 1ns/10ps
`default_nettype none
module bps_segmenter (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire logic [31:0]        in_len,
    input  wire bps_pkg::bps_beat_s in_beat,
    input  wire logic               in_valid,
    output logic                    in_ready,
    output bps_pkg::bps_hdr_s       out_hdr,
    output bps_pkg::bps_beat_s      out_beat,
    output logic                    out_sop,
    output logic                    out_valid,
    input  wire logic               out_ready,
    output logic                    irq
);
    import bps_pkg::*;

    typedef enum logic [1:0] {
        BPS_IDLE = 2'b00,
        BPS_HDR  = 2'b01,
        BPS_PAY  = 2'b11
    } bps_state_e;

    bps_state_e      state_q;
    logic [31:0]     ctrl_q, pipe_q, tstamp_q, segmax_q;
    logic [31:0]     emit_sec_q, emit_ns_q;
    logic [BPS_IRQ_W-1:0] irq_en_q, irq_clr, irq_stat_q, irq_ev;
    logic [31:0]     remain_q;    // bytes left in structure
    logic [15:0]     segleft_q;   // bytes left in current packet
    logic [15:0]     seq_q;
    logic            first_q;
    logic [31:0]     set_len_q, set_ts_q;
    logic [15:0]     seg_size;
    logic [31:0]     ts_now;
    logic            beat_go;
    logic            last_beat;
    logic [15:0]     port_d;

    bps_axil_regs u_regs (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .ctrl_q        (ctrl_q),
        .pipe_q        (pipe_q),
        .tstamp_q      (tstamp_q),
        .segmax_q      (segmax_q),
        .emit_sec_q    (emit_sec_q),
        .emit_ns_q     (emit_ns_q),
        .irq_en_q      (irq_en_q),
        .irq_clr       (irq_clr),
        .irq_stat      (irq_stat_q),
        .status        ({28'h0, remain_q != 32'h0, first_q,
                         state_q}),
        .seq_now       (seq_q)
    );

    // timestamp either raw or derived from emission time
    assign ts_now = ctrl_q[BPS_CTRL_TSSRC_BIT]
        ? {emit_sec_q[BPS_TS_SEC_W-1:0],
           emit_ns_q[BPS_TS_NS_MSB -: BPS_TS_NS_W]}
        : tstamp_q;

    // zero segment size would stall forever, so treat it as one byte
    assign seg_size = (segmax_q[15:0] == 16'h0) ? 16'h0001 : segmax_q[15:0];

    // pipe port first, then the channel offset on top
    assign port_d = BPS_PORT_BASE
        + {10'h0, pipe_q[BPS_PIPE_LSB +: BPS_PIPE_W]}
        + {8'h0, pipe_q[BPS_CHOFF_LSB +: BPS_CHOFF_W]};

    assign beat_go   = (state_q == BPS_PAY) && in_valid && in_ready;
    assign last_beat = (segleft_q == 16'h1) || (remain_q == 32'h1);
    // input is only taken when the output slot is free
    assign in_ready  = (state_q == BPS_PAY) && (!out_valid || out_ready);

    // framing state machine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q   <= BPS_IDLE;
            remain_q  <= 32'h0;
            segleft_q <= 16'h0;
            first_q   <= 1'b0;
            set_len_q <= 32'h0;
            set_ts_q  <= 32'h0;
        end else begin
            case (state_q)
                BPS_IDLE: begin
                    if (ctrl_q[BPS_CTRL_ENABLE_BIT] && in_valid
                        && in_len != 32'h0) begin
                        set_len_q <= in_len;
                        remain_q  <= in_len;
                        set_ts_q  <= ts_now;
                        first_q   <= 1'b1;
                        state_q   <= BPS_HDR;
                    end
                end
                BPS_HDR: begin
                    if (!out_valid || out_ready) begin
                        segleft_q <= (remain_q < {16'h0, seg_size})
                                     ? remain_q[15:0] : seg_size;
                        state_q   <= BPS_PAY;
                    end
                end
                BPS_PAY: begin
                    if (beat_go) begin
                        remain_q  <= remain_q - 32'h1;
                        segleft_q <= segleft_q - 16'h1;
                        if (remain_q == 32'h1) begin
                            state_q <= BPS_IDLE;
                        end else if (segleft_q == 16'h1) begin
                            first_q <= 1'b0;
                            state_q <= BPS_HDR;
                        end
                    end
                end
                default: state_q <= BPS_IDLE;
            endcase
        end
    end

    // output stage: one header beat marked by sop, then payload bytes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_valid <= 1'b0;
            out_sop   <= 1'b0;
            out_beat  <= '0;
            out_hdr   <= '0;
        end else begin
            if (out_valid && out_ready) begin
                out_valid <= 1'b0;
            end
            if (state_q == BPS_HDR && (!out_valid || out_ready)) begin
                out_valid             <= 1'b1;
                out_sop               <= 1'b1;
                out_beat              <= '0;
                out_hdr.dst_addr      <= BPS_MCAST_ADDR;
                out_hdr.dst_port      <= port_d;
                out_hdr.version       <= BPS_RTP_VER;
                out_hdr.padding       <= ctrl_q[BPS_CTRL_PAD_BIT];
                out_hdr.extension     <= ctrl_q[BPS_CTRL_EXT_BIT];
                out_hdr.csrc_count    <= BPS_CSRC_COUNT;
                out_hdr.marker        <= first_q;
                out_hdr.payload_type  <= BPS_PT_BASEBAND;
                out_hdr.seq_num       <= seq_q;
                out_hdr.timestamp     <= set_ts_q;
                out_hdr.ssrc          <= first_q ? set_len_q
                                                 : 32'h0;
                out_hdr.pay_len       <= (remain_q < {16'h0, seg_size})
                                         ? remain_q[15:0] : seg_size;
            end else if (beat_go) begin
                out_valid     <= 1'b1;
                out_sop       <= 1'b0;
                out_beat.data <= in_beat.data;
                out_beat.last <= last_beat;
            end
        end
    end

    // sequence number advances once per packet header emitted
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_q <= 16'h0;
        end else if (state_q == BPS_HDR && (!out_valid || out_ready)) begin
            seq_q <= seq_q + 16'h1;
        end
    end

    // sticky events: set wins over a clear in the same cycle
    assign irq_ev[BPS_IRQ_SET_DONE] = beat_go && remain_q == 32'h1;
    assign irq_ev[BPS_IRQ_PKT_DONE] = beat_go && last_beat;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
        end
    end

    // level interrupt registered so the output comes from a flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((irq_stat_q & ~irq_clr) | irq_ev) & irq_en_q);
        end
    end

    // marker must mean first packet and only then carry a length
    chk_marker_ssrc: assert property (@(posedge aclk)
        disable iff (!aresetn)
        out_valid && out_sop && !out_hdr.marker |-> out_hdr.ssrc == 32'h0)
        else $error("continuation packet carries nonzero ssrc");
    chk_first_len: assert property (@(posedge aclk)
        disable iff (!aresetn)
        out_valid && out_sop && out_hdr.marker |-> out_hdr.ssrc == set_len_q)
        else $error("first packet ssrc differs from length");
    chk_fixed_fields: assert property (@(posedge aclk)
        disable iff (!aresetn)
        out_valid && out_sop |-> out_hdr.payload_type == 7'h4e
            && out_hdr.csrc_count == 4'h0
            && out_hdr.dst_addr == 32'hef00_3330)
        else $error("fixed header field wrong");
    chk_port_range: assert property (@(posedge aclk)
        disable iff (!aresetn)
        out_valid && out_sop |-> out_hdr.dst_port == 16'd30000
            + {10'h0, pipe_q[5:0]} + {8'h0, pipe_q[15:8]})
        else $error("destination port wrong");
    chk_seq_step: assert property (@(posedge aclk)
        disable iff (!aresetn)
        state_q == BPS_HDR && (!out_valid || out_ready)
        |=> seq_q == $past(seq_q) + 16'h1)
        else $error("sequence did not advance by one");
    chk_ts_hold: assert property (@(posedge aclk)
        disable iff (!aresetn)
        out_valid && out_sop && !out_hdr.marker
        |-> out_hdr.timestamp == set_ts_q)
        else $error("timestamp changed within set");
    chk_marker_once: assert property (@(posedge aclk)
        disable iff (!aresetn)
        state_q == BPS_PAY && segleft_q == 16'h1 && remain_q > 32'h1
        && beat_go |=> !first_q)
        else $error("marker persists after first packet");
    chk_ext_bit: assert property (@(posedge aclk)
        disable iff (!aresetn)
        state_q == BPS_HDR && (!out_valid || out_ready)
        |=> out_hdr.extension == $past(ctrl_q[BPS_CTRL_EXT_BIT]))
        else $error("extension bit mismatch");
    chk_seg_size: assert property (@(posedge aclk)
        disable iff (!aresetn)
        out_valid && out_sop |-> out_hdr.pay_len <= seg_size
            && out_hdr.pay_len != 16'h0)
        else $error("segment length out of range");
    chk_ts_source: assert property (@(posedge aclk)
        disable iff (!aresetn)
        state_q == BPS_IDLE && ctrl_q[BPS_CTRL_TSSRC_BIT]
        && ctrl_q[BPS_CTRL_ENABLE_BIT] && in_valid && in_len != 32'h0
        |=> set_ts_q == {$past(emit_sec_q[21:0]), $past(emit_ns_q[29:20])})
        else $error("derived timestamp wrong");
    // a stalled beat must not change under the consumer, or bytes are lost
    chk_out_hold: assert property (@(posedge aclk)
        disable iff (!aresetn)
        out_valid && !out_ready |=> out_valid && $stable(out_sop)
            && $stable(out_beat) && $stable(out_hdr))
        else $error("output beat changed before it was taken");
    // bytes are only consumed while a packet body is open
    chk_in_gated: assert property (@(posedge aclk)
        disable iff (!aresetn)
        state_q != BPS_PAY |-> !in_ready)
        else $error("input taken outside a packet body");
endmodule
`default_nettype wire

// ### tb/bps_consumer.sv
// data consumer model rebuilding baseband structures
`timescale 1ns/10ps
`default_nettype none
module bps_consumer (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              slow,
    input  wire bps_pkg::bps_hdr_s hdr,
    input  wire logic              sop,
    input  wire logic              valid,
    output logic                   ready,
    output logic [7:0]             done_n,
    output logic [7:0]             lost_n
);
    import bps_pkg::*;
    logic [31:0] len_q;
    logic [31:0] cnt_q;
    logic [15:0] seq_q;
    logic        tog_q;
    // slow mode stalls every other cycle
    assign ready = !slow || tog_q;
    // a gap or early marker drops the set, then waits for a marker
    always_ff @(posedge aclk) begin
        tog_q <= aresetn && !tog_q;
        if (!aresetn) begin
            len_q  <= '0;
            cnt_q  <= '0;
            done_n <= '0;
            lost_n <= '0;
        end else if (valid && ready && sop) begin
            seq_q <= hdr.seq_num;
            if (hdr.marker || hdr.seq_num != seq_q + 16'h1) begin
                lost_n <= lost_n + {7'h0, len_q != 0};
                len_q  <= hdr.marker ? hdr.ssrc : '0;
                cnt_q  <= '0;
            end
        end else if (valid && ready && len_q != 0) begin
            cnt_q <= cnt_q + 1;
            if (cnt_q + 1 == len_q) begin
                done_n <= done_n + 8'h1;
                len_q  <= '0;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the baseband packet segmenter
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import bps_pkg::*;
    logic        aclk, aresetn, awv, wv, bry, arv, rry, ivld, slow, ext;
    logic        awr, wrdy, bv, arr, rv, irdy, ordy, sop, ovld, irq, sq;
    logic [7:0]  awa, ara, bdat, eb, dn, ln;
    logic [31:0] wd, rdat, ilen, nb, ets;
    logic [15:0] lseq;
    logic [1:0]  rr, br;
    bps_hdr_s    hdr;
    bps_beat_s   ob;
    int          fail_count, checks, hn, pl;
    bps_segmenter dut (.aclk, .aresetn, .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .in_len(ilen), .in_beat({bdat, 1'b0}),
        .in_valid(ivld), .in_ready(irdy), .out_hdr(hdr), .out_beat(ob),
        .out_sop(sop), .out_valid(ovld), .out_ready(ordy), .irq);
    bps_consumer far (.aclk, .aresetn, .slow, .hdr, .sop, .valid(ovld),
        .ready(ordy), .done_n(dn), .lost_n(ln));
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task final_report;
        if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one bounded wait step; a hang ends the run
    task step(inout int n);
        @(posedge aclk);
        n++;
        if (n > 500) begin
            fail_count++;
            final_report;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        awa <= a;
        wd <= d;
        {awv, wv, bry} <= 3'b111;
        do begin
            step(n);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (!bv);
        bry <= 1'b0;
        chk(br, BPS_RESP_OKAY);
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        ara <= a;
        {arv, rry} <= 2'b11;
        do begin
            step(n);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rry <= 1'b0;
        chk(rdat, e);
        chk(rr, r);
    endtask
    task send(input logic [31:0] len, input logic s);
        int n;
        logic [7:0] d0;
        n = 0;
        d0 = dn;
        @(posedge aclk);
        ilen <= len;
        nb <= '0;
        slow <= s;
        ivld <= 1'b1;
        hn = 0;
        while (dn == d0) step(n);
    endtask
    // counting bytes; the offer drops with the last byte of the set
    always @(posedge aclk) begin
        if (ivld && irdy) begin
            bdat <= bdat + 8'h1;
            nb <= nb + 1;
            if (nb + 1 == ilen) ivld <= 1'b0;
        end
    end
    // every header and byte the consumer takes is checked
    always @(posedge aclk) begin
        if (ovld && ordy && sop) begin
            chk(hdr.dst_addr, 32'hef00_3330);
            chk(hdr.dst_port, 16'd30008);
            chk({hdr.csrc_count, hdr.payload_type}, 11'h04e);
            chk(hdr.marker, hn == 0);
            chk(hdr.ssrc, hn == 0 ? ilen : 0);
            chk(hdr.timestamp, ets);
            chk({hdr.extension, hdr.padding}, {ext, 1'b0});
            pl = ilen - 2 * hn > 2 ? 2 : ilen - 2 * hn;
            chk(hdr.pay_len, pl);
            if (sq) chk(hdr.seq_num, lseq + 16'h1);
            lseq = hdr.seq_num;
            sq = 1'b1;
            hn++;
        end else if (ovld && ordy) begin
            chk(ob.data, eb);
            eb = eb + 8'h1;
            pl--;
            chk(ob.last, pl == 0);
        end
    end
    initial begin
        {aresetn, awv, wv, bry, arv, rry, ivld, slow, ext, sq} = '0;
        {awa, ara, bdat, eb, wd, ilen, nb, ets} = '0;
        {fail_count, checks, hn, pl} = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        wr(BPS_REG_SEGMAX, 32'd2);
        wr(BPS_REG_PIPE, 32'h0000_0305);
        wr(BPS_REG_TSTAMP, 32'h1234_5678);
        ets = 32'h1234_5678;
        send(32'd5, 1'b0);
        chk(irq, 1'b0);
        wr(BPS_REG_IRQ_EN, 32'h1);
        repeat (3) @(posedge aclk);
        chk(irq, 1'b1);
        rchk(BPS_REG_IRQ_STAT, 32'h3, BPS_RESP_OKAY);
        wr(BPS_REG_IRQ_CLR, 32'h3);
        repeat (3) @(posedge aclk);
        chk(irq, 1'b0);
        rchk(8'h40, 32'h0, BPS_RESP_SLVERR);
        wr(BPS_REG_EMIT_SEC, 32'hffc0_0003);
        wr(BPS_REG_EMIT_NS, 32'h2abc_def0);
        wr(BPS_REG_CTRL, 32'h0000_000b);
        {ets, ext} = {22'h3, 10'h2ab, 1'b1};
        send(32'd3, 1'b1);
        chk(dn, 8'd2);
        chk(ln, 8'h0);
        final_report;
    end
endmodule
`default_nettype wire
